//--- include/rtrp_pkg.sv
// shared constants and types of the remote result processing block
package rtrp_pkg;

  // ---------------------------------------------------------------
  // register pointers
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MAKER_ID   = 8'hfe;
  localparam logic [7:0] ADDR_VIOL_CFG   = 8'h22;
  localparam logic [7:0] ADDR_NONIDEAL   = 8'h23;
  localparam logic [7:0] ADDR_AVG_SEL    = 8'h24;
  localparam logic [7:0] ADDR_RRES_HI    = 8'h30;
  localparam logic [7:0] ADDR_RRES_LO    = 8'h31;
  localparam logic [7:0] ADDR_ALARM_STAT = 8'h32;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  // arbitrary identity value
  localparam logic [7:0] MAKER_ID_VALUE  = 8'ha3;
  localparam int         VIOL_LSB        = 1;
  localparam int         VIOL_MSB        = 3;
  localparam int         TIMEOUT_BIT     = 7;
  localparam logic [7:0] VIOL_WR_MASK    = 8'h8e;
  localparam logic [7:0] RST_VIOL_CFG    = 8'h00;
  localparam logic [7:0] RST_NONIDEAL    = 8'h00;
  localparam logic [7:0] RST_AVG_SEL     = 8'h00;
  localparam logic [7:0] AVG_OFF         = 8'h00;
  localparam logic [7:0] AVG_FOUR        = 8'h01;

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  localparam logic [11:0] ETA_BASE       = 12'h800;
  localparam int          FRAC_BITS      = 11;
  localparam logic [4:0]  DIV_LAST       = 5'h1a;
  localparam int          HIST_DEPTH     = 8;
  localparam logic [2:0]  RUN_MAX        = 3'h4;
  localparam logic [15:0] SAT_POS        = 16'h7fff;
  localparam logic [15:0] SAT_NEG        = 16'h8000;

  typedef enum logic {DIV_IDLE, DIV_RUN} rtrp_div_state_t;

endpackage : rtrp_pkg

//--- include/rtrp_div_if.sv
// divider request and answer bundle
`timescale 1ns/1ns
interface rtrp_div_if;
  logic        start;
  logic [26:0] dividend;
  logic [11:0] divisor;
  logic        busy;
  logic        done;
  logic [16:0] quotient;

  modport master (output start, output dividend, output divisor,
                  input busy, input done, input quotient);
  modport slave  (input start, input dividend, input divisor,
                  output busy, output done, output quotient);
endinterface : rtrp_div_if

//--- core/rtrp_div.sv
// serial restoring divider for the ideality correction
`timescale 1ns/1ns
module rtrp_div (
  input wire logic  core_clk,
  input wire logic  resetn,
  rtrp_div_if.slave div
);

  rtrp_pkg::rtrp_div_state_t state_reg, state_next;
  logic [4:0]  cnt_reg,  cnt_next;
  logic [12:0] rem_reg,  rem_next;
  logic [26:0] quo_reg,  quo_next;
  logic [11:0] dsr_reg,  dsr_next;
  logic        done_reg, done_next;
  logic [12:0] rem_sh;
  logic        fits;

  // ---------------------------------------------------------------
  // one quotient bit per cycle
  // ---------------------------------------------------------------
  // slow but tiny; conversions are milliseconds apart
  always_comb
  begin
    rem_sh     = {rem_reg[11:0], quo_reg[26]};
    fits       = rem_sh >= {1'b0, dsr_reg};
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rem_next   = rem_reg;
    quo_next   = quo_reg;
    dsr_next   = dsr_reg;
    done_next  = 1'b0;
    case (state_reg)
      rtrp_pkg::DIV_IDLE:
      begin
        if (div.start)
        begin
          state_next = rtrp_pkg::DIV_RUN;
          cnt_next   = 5'h00;
          rem_next   = 13'h0000;
          quo_next   = div.dividend;
          dsr_next   = div.divisor;
        end
      end
      rtrp_pkg::DIV_RUN:
      begin
        rem_next = fits ? (rem_sh - {1'b0, dsr_reg}) : rem_sh;
        quo_next = {quo_reg[25:0], fits};
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == rtrp_pkg::DIV_LAST)
        begin
          state_next = rtrp_pkg::DIV_IDLE;
          done_next  = 1'b1;
        end
      end
      default:
      begin
        state_next = rtrp_pkg::DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_reg <= rtrp_pkg::DIV_IDLE;
      cnt_reg   <= 5'h00;
      rem_reg   <= 13'h0000;
      quo_reg   <= 27'h0000000;
      dsr_reg   <= rtrp_pkg::ETA_BASE;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      rem_reg   <= rem_next;
      quo_reg   <= quo_next;
      dsr_reg   <= dsr_next;
      done_reg  <= done_next;
    end
  end

  assign div.busy     = (state_reg == rtrp_pkg::DIV_RUN);
  assign div.done     = done_reg;
  assign div.quotient = quo_reg[16:0];

endmodule : rtrp_div

//--- core/rtrp_top.sv
// remote result correction, averaging and alarm qualification
//
// Notes on behaviour
// - alarm asserts only after the programmed run of consecutive limit violations
// - after reset one violating conversion is enough for the alarm
// - ideality register is a signed byte, minus 128 to plus 127
// - remote result is scaled by 2048 over 2048 plus that byte
// - ideality register resets to zero, giving a factor of exactly one
// - averaging acts on remote results only; zero, the reset value, disables it
// - averaging reports the mean of the last four or last eight remote results
// - pointer fe returns a fixed identity byte that writes never change
// - run length sits in bits 3 to 1, bus time-out enable in bit 7
`timescale 1ns/1ns
module rtrp_top (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        conv_done,
  input  wire logic        conv_remote,
  input  wire logic [15:0] conv_raw,
  input  wire logic        conv_beyond_limit,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [15:0] remote_result,
  output logic             result_valid,
  output logic             alarm_n,
  output logic             bus_timeout_enable
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] rtrp_run_need(input logic [2:0] code);
    if (code[2])      rtrp_run_need = 3'h4;
    else if (code[1]) rtrp_run_need = 3'h3;
    else if (code[0]) rtrp_run_need = 3'h2;
    else              rtrp_run_need = 3'h1;
  endfunction : rtrp_run_need

  rtrp_div_if div_bus ();

  rtrp_div u_div (
    .core_clk (core_clk),
    .resetn   (resetn),
    .div      (div_bus.slave)
  );

  localparam int HIST_DEPTH_L = rtrp_pkg::HIST_DEPTH;

  logic [7:0]  viol_cfg_reg,  viol_cfg_next;
  logic [7:0]  nonideal_reg,  nonideal_next;
  logic [7:0]  avg_sel_reg,   avg_sel_next;
  logic [7:0]  rdata_reg,     rdata_next;
  logic [2:0]  run_reg [2];
  logic [2:0]  run_next [2];
  logic        alarm_reg,     alarm_next;
  logic [2:0]  need;
  logic        sign_reg,      sign_next;
  logic [15:0] rres_reg,      rres_next;
  logic        valid_reg,     valid_next;
  logic [15:0] hist_reg [HIST_DEPTH_L];
  logic [15:0] hist_next [HIST_DEPTH_L];
  logic [15:0] corr;
  logic [15:0] mag;
  logic [18:0] sum4;
  logic [18:0] sum8;
  logic        div_take;

  assign need = rtrp_run_need(viol_cfg_reg[rtrp_pkg::VIOL_MSB:rtrp_pkg::VIOL_LSB]);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_comb
  begin
    viol_cfg_next = viol_cfg_reg;
    nonideal_next = nonideal_reg;
    avg_sel_next  = avg_sel_reg;
    rdata_next    = rdata_reg;
    if (reg_wr)
    begin
      case (reg_addr)
        rtrp_pkg::ADDR_VIOL_CFG: viol_cfg_next = reg_wdata & rtrp_pkg::VIOL_WR_MASK;
        rtrp_pkg::ADDR_NONIDEAL: nonideal_next = reg_wdata;
        rtrp_pkg::ADDR_AVG_SEL:  avg_sel_next  = reg_wdata;
        default:                 viol_cfg_next = viol_cfg_reg; // identity stays fixed
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        rtrp_pkg::ADDR_MAKER_ID:   rdata_next = rtrp_pkg::MAKER_ID_VALUE;
        rtrp_pkg::ADDR_VIOL_CFG:   rdata_next = viol_cfg_reg;
        rtrp_pkg::ADDR_NONIDEAL:   rdata_next = nonideal_reg;
        rtrp_pkg::ADDR_AVG_SEL:    rdata_next = avg_sel_reg;
        rtrp_pkg::ADDR_RRES_HI:    rdata_next = rres_reg[15:8];
        rtrp_pkg::ADDR_RRES_LO:    rdata_next = rres_reg[7:0];
        rtrp_pkg::ADDR_ALARM_STAT: rdata_next = {7'h00, alarm_reg};
        default:                   rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      viol_cfg_reg <= rtrp_pkg::RST_VIOL_CFG;
      nonideal_reg <= rtrp_pkg::RST_NONIDEAL;
      avg_sel_reg  <= rtrp_pkg::RST_AVG_SEL;
      rdata_reg    <= 8'h00;
    end
    else
    begin
      viol_cfg_reg <= viol_cfg_next;
      nonideal_reg <= nonideal_next;
      avg_sel_reg  <= avg_sel_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // violation runs, local is channel 0, remote channel 1
  // ---------------------------------------------------------------
  always_comb
  begin
    alarm_next = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      run_next[c] = run_reg[c];
      if (conv_done && (conv_remote == (c == 1)))
      begin
        if (!conv_beyond_limit)      run_next[c] = 3'h0;
        else if (run_reg[c] != rtrp_pkg::RUN_MAX) run_next[c] = run_reg[c] + 3'h1;
      end
      if (run_next[c] >= need)
      begin
        alarm_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      run_reg[0] <= 3'h0;
      run_reg[1] <= 3'h0;
      alarm_reg  <= 1'b0;
    end
    else
    begin
      run_reg[0] <= run_next[0];
      run_reg[1] <= run_next[1];
      alarm_reg  <= alarm_next;
    end
  end

  // ---------------------------------------------------------------
  // remote correction and averaging
  // ---------------------------------------------------------------
  // a remote result arriving while the divider is busy is dropped
  assign div_take         = conv_done && conv_remote && !div_bus.busy;
  assign mag              = conv_raw[15] ? (16'h0000 - conv_raw) : conv_raw;
  assign div_bus.start    = div_take;
  assign div_bus.dividend = {mag, 11'h000};
  assign div_bus.divisor  = rtrp_pkg::ETA_BASE + {{4{nonideal_reg[7]}}, nonideal_reg};

  always_comb
  begin
    sign_next  = div_take ? conv_raw[15] : sign_reg;
    valid_next = div_bus.done;
    rres_next  = rres_reg;
    corr       = 16'h0000;
    sum4       = 19'h00000;
    sum8       = 19'h00000;
    // saturate, the factor can push a full-scale reading past 16 bits
    if (sign_reg)
      corr = (div_bus.quotient > 17'h08000) ? rtrp_pkg::SAT_NEG
           : 16'(17'h00000 - div_bus.quotient);
    else
      corr = (div_bus.quotient > 17'h07fff) ? rtrp_pkg::SAT_POS : div_bus.quotient[15:0];
    for (int i = 0; i < HIST_DEPTH_L; i++)
    begin
      if (!div_bus.done)  hist_next[i] = hist_reg[i];
      else if (i == 0)    hist_next[i] = corr;
      else                hist_next[i] = hist_reg[i-1];
      sum8 = sum8 + {{3{hist_next[i][15]}}, hist_next[i]};
      if (i < 4) sum4 = sum4 + {{3{hist_next[i][15]}}, hist_next[i]};
    end
    if (div_bus.done)
    begin
      if (avg_sel_reg == rtrp_pkg::AVG_OFF)       rres_next = corr;
      else if (avg_sel_reg == rtrp_pkg::AVG_FOUR) rres_next = sum4[17:2];
      else                                        rres_next = sum8[18:3];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sign_reg  <= 1'b0;
      rres_reg  <= 16'h0000;
      valid_reg <= 1'b0;
      for (int i = 0; i < HIST_DEPTH_L; i++) hist_reg[i] <= 16'h0000;
    end
    else
    begin
      sign_reg  <= sign_next;
      rres_reg  <= rres_next;
      valid_reg <= valid_next;
      for (int i = 0; i < HIST_DEPTH_L; i++) hist_reg[i] <= hist_next[i];
    end
  end

  assign reg_rdata          = rdata_reg;
  assign remote_result      = rres_reg;
  assign result_valid       = valid_reg;
  assign alarm_n            = !alarm_reg;
  assign bus_timeout_enable = viol_cfg_reg[rtrp_pkg::TIMEOUT_BIT];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_div_start;
    div_bus.start;
  endsequence

  sequence s_div_answer;
    ##28 div_bus.done;
  endsequence

  property p_alarm_cause;
    @(posedge core_clk) disable iff (!resetn)
    !alarm_n && $stable(viol_cfg_reg) |-> (run_reg[0] >= need) || (run_reg[1] >= need);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without a full run");

  property p_single_default;
    @(posedge core_clk) disable iff (!resetn)
    conv_done && conv_beyond_limit && (viol_cfg_reg[3:1] == 3'h0) |=> !alarm_n;
  endproperty
  a_single_default: assert property (p_single_default) else $error("one violation missed");

  property p_reset_values;
    @(posedge core_clk) disable iff (!resetn)
    $rose(resetn) |-> (viol_cfg_reg == 8'h00) && (nonideal_reg == 8'h00) && (avg_sel_reg == 8'h00);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_divisor;
    @(posedge core_clk) disable iff (!resetn)
    div_bus.start |-> div_bus.divisor == 12'(12'sd2048 + 12'($signed(nonideal_reg)));
  endproperty
  a_divisor: assert property (p_divisor) else $error("wrong ideality divisor");

  property p_div_latency;
    @(posedge core_clk) disable iff (!resetn)
    s_div_start |-> s_div_answer;
  endproperty
  a_div_latency: assert property (p_div_latency) else $error("divider answer late");

  property p_filter_off;
    @(posedge core_clk) disable iff (!resetn)
    div_bus.done && (avg_sel_reg == 8'h00) |=> remote_result == $past(corr) && result_valid;
  endproperty
  a_filter_off: assert property (p_filter_off) else $error("unfiltered result wrong");

  property p_filter_eight;
    @(posedge core_clk) disable iff (!resetn)
    div_bus.done && (avg_sel_reg == 8'h02) |=> remote_result == $past(sum8[18:3]);
  endproperty
  a_filter_eight: assert property (p_filter_eight) else $error("mean of eight wrong");

  property p_identity;
    @(posedge core_clk) disable iff (!resetn)
    reg_rd && (reg_addr == 8'hfe) |=> reg_rdata == rtrp_pkg::MAKER_ID_VALUE;
  endproperty
  a_identity: assert property (p_identity) else $error("identity byte wrong");

  property p_timeout_bit;
    @(posedge core_clk) disable iff (!resetn)
    reg_wr && (reg_addr == rtrp_pkg::ADDR_VIOL_CFG) |=> bus_timeout_enable == $past(reg_wdata[7]);
  endproperty
  a_timeout_bit: assert property (p_timeout_bit) else $error("time-out bit wrong");

  property p_run_restart;
    @(posedge core_clk) disable iff (!resetn)
    conv_done && !conv_remote && !conv_beyond_limit |=> run_reg[0] == 3'h0;
  endproperty
  a_run_restart: assert property (p_run_restart) else $error("run not restarted");

endmodule : rtrp_top

//--- tb/rtrp_host.sv
// register host model driving the pointer bus of the result block
`timescale 1ns/1ns
module rtrp_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : rtrp_host

//--- tb/rtrp_top_bench.sv
// self-checking bench of the remote result processing block
`timescale 1ns/1ns
module rtrp_top_bench;
  logic        core_clk;
  logic        resetn;
  logic        conv_done;
  logic        conv_remote;
  logic [15:0] conv_raw;
  logic        conv_beyond_limit;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [15:0] remote_result;
  logic        result_valid;
  logic        alarm_n;
  logic        bus_timeout_enable;
  int          n_fail;
  int          samples_checked;
  int          hist[8];
  int          avg_k;
  int          avg_sh;
  logic [7:0]  n_cur;

  rtrp_top u_dut (.core_clk(core_clk), .resetn(resetn), .conv_done(conv_done),
    .conv_remote(conv_remote), .conv_raw(conv_raw), .conv_beyond_limit(conv_beyond_limit),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .remote_result(remote_result), .result_valid(result_valid),
    .alarm_n(alarm_n), .bus_timeout_enable(bus_timeout_enable));

  rtrp_host u_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  // ---------------------------------------------------------------
  // compare and closing
  // ---------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16

  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // truncation toward zero, then saturation to the result range
  function automatic logic [15:0] corr(input logic [15:0] raw, input logic [7:0] n);
    longint mag;
    longint q;
    mag = raw[15] ? -longint'($signed(raw)) : longint'(raw);
    q = (mag * 2048) / (2048 + longint'($signed(n)));
    if (raw[15])
      q = -q;
    if (q > 32767)
      q = 32767;
    if (q < -32768)
      q = -32768;
    return q[15:0];
  endfunction : corr

  // one conversion; remote ones are waited for and judged
  task automatic conv(input logic rm, input logic [15:0] raw, input logic bey);
    logic [15:0] e;
    logic [7:0]  b;
    int          sum;
    int          k;
    @(posedge core_clk);
    conv_done         <= 1'b1;
    conv_remote       <= rm;
    conv_raw          <= raw;
    conv_beyond_limit <= bey;
    @(posedge core_clk);
    conv_done <= 1'b0;
    conv_raw  <= ~raw;
    if (!rm)
    begin
      repeat (2) @(posedge core_clk);
      #1;
      return;
    end
    for (k = 7; k > 0; k--)
      hist[k] = hist[k-1];
    hist[0] = int'($signed(corr(raw, n_cur)));
    sum = 0;
    for (k = 0; k < ((avg_k == 0) ? 1 : avg_k); k++)
      sum += hist[k];
    sum = sum >>> avg_sh;
    e = sum[15:0];
    k = 0;
    while (result_valid !== 1'b1 && k < 40)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk1("result_valid", 1'b1, result_valid);
    chk16("remote_result", e, remote_result);
    u_host.rd(rtrp_pkg::ADDR_RRES_HI, b);
    chk8("result_hi", e[15:8], b);
    u_host.rd(rtrp_pkg::ADDR_RRES_LO, b);
    chk8("result_lo", e[7:0], b);
  endtask : conv

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    u_host.rd(rtrp_pkg::ADDR_VIOL_CFG, d);
    chk8("viol_cfg", rtrp_pkg::RST_VIOL_CFG, d);
    u_host.rd(rtrp_pkg::ADDR_NONIDEAL, d);
    chk8("nonideal", rtrp_pkg::RST_NONIDEAL, d);
    u_host.rd(rtrp_pkg::ADDR_AVG_SEL, d);
    chk8("avg_sel", rtrp_pkg::RST_AVG_SEL, d);
    u_host.rd(8'h40, d);
    chk8("unmapped", 8'h00, d);
    chk1("alarm_n", 1'b1, alarm_n);
    chk1("bus_timeout_enable", 1'b0, bus_timeout_enable);
    conv(1'b0, 16'h0000, 1'b1);
    chk1("alarm_n", 1'b0, alarm_n);
    conv(1'b0, 16'h0000, 1'b0);
    chk1("alarm_n", 1'b1, alarm_n);
  endtask : t_reset

  task automatic t_ident();
    logic [7:0] d;
    u_host.wr(rtrp_pkg::ADDR_MAKER_ID, ~rtrp_pkg::MAKER_ID_VALUE);
    u_host.rd(rtrp_pkg::ADDR_MAKER_ID, d);
    chk8("maker_identity", rtrp_pkg::MAKER_ID_VALUE, d);
  endtask : t_ident

  task automatic t_alarm();
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2, 3'h5};
    int         needs[6] = '{1, 2, 3, 4, 3, 4};
    logic [7:0] w;
    logic [7:0] d;
    for (int i = 0; i < 6; i++)
    begin
      w = {i[0], 3'h7, codes[i], 1'b1};
      u_host.wr(rtrp_pkg::ADDR_VIOL_CFG, w);
      u_host.rd(rtrp_pkg::ADDR_VIOL_CFG, d);
      chk8("viol_cfg", w & rtrp_pkg::VIOL_WR_MASK, d);
      chk1("bus_timeout_enable", i[0], bus_timeout_enable);
      repeat (needs[i] - 1) conv(1'b0, 16'h0000, 1'b1);
      chk1("alarm_n", 1'b1, alarm_n);
      conv(1'b0, 16'h0000, 1'b0);
      repeat (needs[i] - 1) conv(1'b0, 16'h0000, 1'b1);
      chk1("alarm_n", 1'b1, alarm_n);
      conv(1'b0, 16'h0000, 1'b1);
      chk1("alarm_n", 1'b0, alarm_n);
      conv(1'b0, 16'h0000, 1'b0);
      chk1("alarm_n", 1'b1, alarm_n);
    end
  endtask : t_alarm

  task automatic t_corr();
    logic [7:0]  ns[5]   = '{8'h00, 8'h7f, 8'h80, 8'h10, 8'hf0};
    logic [15:0] raws[3] = '{16'h0640, 16'hf9c0, 16'h7fff};
    logic [7:0]  d;
    for (int i = 0; i < 5; i++)
    begin
      u_host.wr(rtrp_pkg::ADDR_NONIDEAL, ns[i]);
      u_host.rd(rtrp_pkg::ADDR_NONIDEAL, d);
      chk8("nonideal", ns[i], d);
      n_cur = ns[i];
      for (int j = 0; j < 3; j++)
        conv(1'b1, raws[j], 1'b0);
    end
  endtask : t_corr

  task automatic t_avg();
    logic [15:0] vals[4] = '{16'h0190, 16'hfe70, 16'h0321, 16'hffff};
    logic [7:0]  sels[4] = '{8'h01, 8'h02, 8'h05, 8'h00};
    int          ks[4]   = '{4, 8, 8, 0};
    logic [15:0] held;
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(rtrp_pkg::ADDR_AVG_SEL, sels[i]);
      avg_k  = ks[i];
      avg_sh = (ks[i] == 4) ? 2 : ((ks[i] == 8) ? 3 : 0);
      for (int j = 0; j < 4; j++)
        conv(1'b1, vals[j], 1'b0);
      held = remote_result;
      conv(1'b0, 16'h1234, 1'b0);
      repeat (35) @(posedge core_clk);
      #1;
      chk16("remote_result", held, remote_result);
    end
  endtask : t_avg

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  always #25 core_clk = ~core_clk;

  initial
  begin
    core_clk          = 1'b0;
    resetn            = 1'b0;
    conv_done         = 1'b0;
    conv_remote       = 1'b0;
    conv_raw          = 16'h0000;
    conv_beyond_limit = 1'b0;
    n_cur             = 8'h00;
    avg_k             = 0;
    avg_sh            = 0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_ident();
    t_alarm();
    t_corr();
    t_avg();
    conclude();
  end

  // hang guard, well beyond the roughly 1500 cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
endmodule : rtrp_top_bench
